//--- verilog/aio_cfg.v
// Audio input/output configuration bank with serial audio slave receiver.
// Assumes bit clock, word clock, data and the warning pin are asynchronous
// to mclk and much slower than it (bit clock at most 64fs of 96 kHz).
//
// Contract
// - Device is always the serial input slave
// - Reset format is I2S, MSB first
// - Accept 32, 48 or 64 fs bit clocks
// - Order bit selects MSB or LSB first
// - At 32fs, 1100 I2S15, 1110 justified 16
// - Low bits framing, high bits word width
// - Order ignored except 16-bit words; code honours it for those only at 32fs or with I2S framing
// - Delay bit delays bit clock one cycle
// - Select bits map left/right to channels
// - Mode field selects output stage timing
// - Mode 11 pulse size is 0-31 ticks
// - Warning low and enabled cuts 3 dB
// - Cut holds until reset
// - Bypass bit disables the warning cut
// - Highpass bypass bit turns filter off
// - De-emphasis bit applies to all channels
`timescale 1ns/1ps
`include "aio_cfg_regs.vh"

module aio_cfg #(
  parameter SAMPLE_W = 24
) (
  // Core clock and reset
  input  wire                mclk,
  input  wire                nrst,
  // Register port
  input  wire [7:0]          reg_addr,
  input  wire [7:0]          reg_wdata,
  input  wire                reg_wr,
  input  wire                reg_rd,
  output reg  [7:0]          reg_rdata,
  // Serial audio input pins
  input  wire                serial_bit_clock_in,
  input  wire                word_clock_in,
  input  wire                serial_data_in,
  // Power stage warning pin
  input  wire                overcurrent_warning_n,
  // Processing channel samples
  output reg  [SAMPLE_W-1:0] ch1_sample,
  output reg  [SAMPLE_W-1:0] ch2_sample,
  output reg                 sample_valid,
  output reg                 bit_ratio_32,
  // Control decode
  output reg  [1:0]          output_stage_mode,
  output reg  [6:0]          comp_pulse_cyc,
  output reg                 mod_limit_cut,
  output reg                 highpass_en,
  output reg                 deemphasis_en
);

  localparam [5:0] SW6   = SAMPLE_W;
  localparam [6:0] TICKC = `AIO_TICK_CYC;

  // Format decode, returns {framing, width}
  function [6:0] fmt_dec;
    input [3:0] code;
    input       r32;
    reg   [4:0] w;
    begin
      w = 5'd24;
      case (code[3:2])
        2'b00:   w = 5'd24;
        2'b01:   w = 5'd20;
        2'b10:   w = 5'd18;
        default: w = 5'd16;
      endcase
      if (r32 && code == `AIO_FMT32_I2S15) begin
        fmt_dec = {`AIO_FR_I2S, 5'd15};
      end else if (r32 && code == `AIO_FMT32_J16) begin
        fmt_dec = {`AIO_FR_LJ, 5'd16};
      end else if (code[1:0] == 2'b11) begin
        fmt_dec = {`AIO_FR_I2S, w}; // Reserved framing falls back to I2S
      end else begin
        fmt_dec = {code[1:0], w};
      end
    end
  endfunction

  // Configuration registers
  reg [7:0] serial_input_config_q;   // Serial format and mapping
  reg [7:0] output_stage_config_q;   // Output stage timing
  reg [7:0] processing_config_q;     // Filter controls

  // Synchronisers, first stage feeds only the second
  reg [1:0] bck_sync_q;              // Bit clock
  reg [1:0] lrk_sync_q;              // Word clock
  reg [1:0] sdi_sync_q;              // Serial data
  reg [1:0] ocw_sync_q;              // Warning pin
  reg       bck_dly_q;               // Bit clock one cycle later
  reg       bck_prev_q;              // Selected clock, last cycle

  // Receiver state
  reg                lr_last_q;      // Word clock at last bit edge
  reg [5:0]          hcnt_q;         // Bits in current half
  reg [SAMPLE_W-1:0] shift_q;        // Incoming bits
  reg [SAMPLE_W-1:0] left_q;         // Left slot of current frame
  reg [3:0]          act_code_q;     // Format code in use
  reg                act_order_q;    // Bit order in use
  reg                act_sel1_q;     // Channel 1 source in use
  reg                act_sel2_q;     // Channel 2 source in use
  reg                oc_cut_q;       // Sticky 3 dB cut
  reg [5:0]          hcnt_len_q;     // Bits in last whole half

  // Register writes; all bits but processing_config_q[7:2] steer the decode below
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      serial_input_config_q <= `AIO_RST_SERIAL_IN;
      output_stage_config_q <= `AIO_RST_OUT_STAGE;
      processing_config_q   <= `AIO_RST_PROC;
    end else if (reg_wr) begin
      case (reg_addr)
        `AIO_OFS_SERIAL_IN: serial_input_config_q <= reg_wdata;
        `AIO_OFS_OUT_STAGE: output_stage_config_q <= reg_wdata;
        `AIO_OFS_PROC:      processing_config_q   <= reg_wdata;
        default: begin
          // Unmapped writes are dropped
        end
      endcase
    end
  end

  // Register reads, unmapped offsets return zero
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `AIO_OFS_SERIAL_IN: reg_rdata <= serial_input_config_q;
        `AIO_OFS_OUT_STAGE: reg_rdata <= output_stage_config_q;
        `AIO_OFS_PROC:      reg_rdata <= processing_config_q;
        default:            reg_rdata <= 8'h00;
      endcase
    end
  end

  // Delayed clock lets data settle against sloppy masters
  wire bck_sel = serial_input_config_q[`AIO_DELAY_BIT] ?
                 bck_dly_q : bck_sync_q[1];

  // Pin synchronisers; the external source owns all serial clocks
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bck_sync_q <= 2'b00;
      lrk_sync_q <= 2'b00;
      sdi_sync_q <= 2'b00;
      ocw_sync_q <= 2'b11;
      bck_dly_q  <= 1'b0;
      bck_prev_q <= 1'b0;
    end else begin
      bck_sync_q <= {bck_sync_q[0], serial_bit_clock_in};
      lrk_sync_q <= {lrk_sync_q[0], word_clock_in};
      sdi_sync_q <= {sdi_sync_q[0], serial_data_in};
      ocw_sync_q <= {ocw_sync_q[0], overcurrent_warning_n};
      bck_dly_q  <= bck_sync_q[1];
      bck_prev_q <= bck_sel;
    end
  end

  wire bit_rise = bck_sel & ~bck_prev_q;
  wire lr_now   = lrk_sync_q[1];
  wire lr_chg   = bit_rise & (lr_now != lr_last_q);

  // Active format decode
  wire       is32    = (hcnt_len_q == `AIO_HALF_32FS);
  wire [6:0] fdec    = fmt_dec(act_code_q, is32);
  wire [1:0] framing = fdec[6:5];
  wire [4:0] width   = fdec[4:0];
  // LSB first only honoured for 16-bit words
  wire lsb16 = act_order_q & (width == 5'd16) &
               (is32 | (framing == `AIO_FR_I2S));
  // Left slot level: I2S low, justified high
  wire left_lvl = (framing != `AIO_FR_I2S);

  // Bit counter and shift register
  wire [5:0] hcnt_inc = (hcnt_q == 6'h3f) ? hcnt_q : hcnt_q + 6'd1;
  wire [5:0] hcnt_d   = lr_chg ? 6'd1 : hcnt_inc;
  wire [SAMPLE_W-1:0] shift_d = {shift_q[SAMPLE_W-2:0], sdi_sync_q[1]};

  // Capture point: end of half for right-justified, else count target
  wire [5:0] tgt = (framing == `AIO_FR_I2S) ? {1'b0, width} + 6'd1
                                            : {1'b0, width};
  wire is_rj = (framing == `AIO_FR_RJ);
  wire cap   = is_rj ? lr_chg : (bit_rise & (hcnt_d == tgt));
  wire [SAMPLE_W-1:0] word = is_rj ? shift_q : shift_d;
  wire cap_left = is_rj ? (lr_last_q == left_lvl) : (lr_now == left_lvl);

  // Reverse a 16-bit word for LSB-first data
  wire [15:0] rev16;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_rev
      assign rev16[gi] = word[15-gi];
    end
  endgenerate

  // Left-align into the sample width; unused upper bits fall off
  wire [5:0] shamt = SW6 - {1'b0, width};
  wire [SAMPLE_W-1:0] rev_al = {rev16, {(SAMPLE_W-16){1'b0}}};
  wire [SAMPLE_W-1:0] aligned = lsb16 ? rev_al : (word << shamt);

  // Receiver: counts, captures, format latching at left slot start
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lr_last_q    <= 1'b0;
      hcnt_q       <= 6'd0;
      hcnt_len_q   <= 6'd0;
      shift_q      <= {SAMPLE_W{1'b0}};
      left_q       <= {SAMPLE_W{1'b0}};
      act_code_q   <= 4'h0;
      act_order_q  <= 1'b0;
      act_sel1_q   <= 1'b0;
      act_sel2_q   <= 1'b1;
      ch1_sample   <= {SAMPLE_W{1'b0}};
      ch2_sample   <= {SAMPLE_W{1'b0}};
      sample_valid <= 1'b0;
      bit_ratio_32 <= 1'b0;
    end else begin
      sample_valid <= 1'b0;
      bit_ratio_32 <= is32;
      if (bit_rise) begin
        lr_last_q <= lr_now;
        hcnt_q    <= hcnt_d;
        shift_q   <= shift_d;
      end
      if (lr_chg) begin
        hcnt_len_q <= hcnt_q;
      end
      // New settings only where a new left slot begins
      if (lr_chg && (lr_now == left_lvl)) begin
        act_code_q  <= serial_input_config_q[`AIO_FMT_MSB:`AIO_FMT_LSB];
        act_order_q <= serial_input_config_q[`AIO_ORDER_BIT];
        act_sel1_q  <= serial_input_config_q[`AIO_CH1_SEL_BIT];
        act_sel2_q  <= serial_input_config_q[`AIO_CH2_SEL_BIT];
      end
      if (cap) begin
        if (cap_left) begin
          left_q <= aligned;
        end else begin
          // Right slot closes the frame
          ch1_sample   <= act_sel1_q ? aligned : left_q;
          ch2_sample   <= act_sel2_q ? aligned : left_q;
          sample_valid <= 1'b1;
        end
      end
    end
  end

  // Sticky over-current cut; only reset clears it
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      oc_cut_q <= 1'b0;
    end else if (!ocw_sync_q[1] &&
                 !output_stage_config_q[`AIO_OC_BYPASS_BIT]) begin
      oc_cut_q <= 1'b1;
    end
  end

  // Control outputs, registered copies of the decode
  wire [1:0] mode_w = output_stage_config_q[`AIO_MODE_MSB:`AIO_MODE_LSB];
  wire [4:0] csz_w  = output_stage_config_q[`AIO_CSZ_MSB:`AIO_CSZ_LSB];
  wire [6:0] csz_c  = {2'b00, csz_w} * TICKC;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      output_stage_mode <= 2'b10;
      comp_pulse_cyc    <= 7'd0;
      mod_limit_cut     <= 1'b0;
      highpass_en       <= 1'b1;
      deemphasis_en     <= 1'b0;
    end else begin
      output_stage_mode <= mode_w;
      // Pulse width only meaningful in variable drop mode
      comp_pulse_cyc <= (mode_w == `AIO_MODE_VAR_DROP) ? csz_c : 7'd0;
      mod_limit_cut  <= oc_cut_q;
      highpass_en    <= ~processing_config_q[`AIO_HPB_BIT];
      deemphasis_en  <= processing_config_q[`AIO_DEEMP_BIT];
    end
  end

endmodule // aio_cfg

//--- verilog/aio_cfg_regs.vh
// Offsets, field positions, reset values and timing counts of the audio
// input/output configuration bank. Definitions only; include by bare name.
`ifndef AIO_CFG_REGS_VH
`define AIO_CFG_REGS_VH
// Register offsets
`define AIO_OFS_SERIAL_IN   8'h01
`define AIO_OFS_OUT_STAGE   8'h02
`define AIO_OFS_PROC        8'h03
// Reset values
`define AIO_RST_SERIAL_IN   8'h80
`define AIO_RST_OUT_STAGE   8'hc2
`define AIO_RST_PROC        8'h40
// serial_input_config fields
`define AIO_FMT_LSB         0
`define AIO_FMT_MSB         3
`define AIO_ORDER_BIT       4
`define AIO_DELAY_BIT       5
`define AIO_CH1_SEL_BIT     6
`define AIO_CH2_SEL_BIT     7
// output_stage_config fields
`define AIO_MODE_LSB        0
`define AIO_MODE_MSB        1
`define AIO_CSZ_LSB         2
`define AIO_CSZ_MSB         6
`define AIO_OC_BYPASS_BIT   7
// processing_config fields
`define AIO_HPB_BIT         0
`define AIO_DEEMP_BIT       1
// Output stage modes
`define AIO_MODE_VAR_DROP   2'h3
// Framing codes
`define AIO_FR_I2S          2'h0
`define AIO_FR_LJ           2'h1
`define AIO_FR_RJ           2'h2
// Format codes special at 32fs
`define AIO_FMT32_I2S15     4'hc
`define AIO_FMT32_J16       4'he
// Bits per half frame at 32fs
`define AIO_HALF_32FS       6'h10
// Compensating pulse tick and core clock period
`define AIO_TICK_NS         10
`define AIO_MCLK_NS         5
`define AIO_TICK_CYC        ((`AIO_TICK_NS + `AIO_MCLK_NS - 1) / `AIO_MCLK_NS)
`endif

//--- bench/aio_cfg_props.sv
// Port checker for the audio configuration bank.
// Assumes it is bound to aio_cfg and sees only that module's ports.
`timescale 1ns/1ps
module aio_cfg_props (
  // Clock, reset and register port
  input wire       mclk,
  input wire       nrst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  // Pins and decoded controls
  input wire       overcurrent_warning_n,
  input wire       sample_valid,
  input wire [1:0] output_stage_mode,
  input wire [6:0] comp_pulse_cyc,
  input wire       mod_limit_cut,
  input wire       highpass_en,
  input wire       deemphasis_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  reg byp_q; // Shadow of the warning bypass bit, rebuilt from port writes
  // Shadow follows writes to the output stage register
  always @(posedge mclk or negedge nrst)
    if (!nrst) byp_q <= 1'b1;
    else if (reg_wr && reg_addr == 8'h02) byp_q <= reg_wdata[7];
  mode_follow_a: assert property (reg_wr && reg_addr == 8'h02 |-> ##2
    output_stage_mode == $past(reg_wdata[1:0], 2)) else $error("mode decode wrong");
  pulse_size_a: assert property (reg_wr && reg_addr == 8'h02 |-> ##2
    comp_pulse_cyc == (($past(reg_wdata[1:0], 2) == 2'h3) ?
    {1'b0, $past(reg_wdata[6:2], 2), 1'b0} : 7'h00)) else $error("pulse size wrong");
  hpf_follow_a: assert property (reg_wr && reg_addr == 8'h03 |-> ##2
    highpass_en == !$past(reg_wdata[0], 2)) else $error("highpass decode wrong");
  deemp_follow_a: assert property (reg_wr && reg_addr == 8'h03 |-> ##2
    deemphasis_en == $past(reg_wdata[1], 2)) else $error("deemphasis decode wrong");
  proc_read_a: assert property (reg_rd && reg_addr == 8'h03 |=>
    reg_rdata[1:0] == {deemphasis_en, !highpass_en}) else $error("readback differs");
  cut_set_a: assert property ((!overcurrent_warning_n && !byp_q) [*6] |=>
    mod_limit_cut) else $error("cut not applied");
  cut_hold_a: assert property (mod_limit_cut |=> mod_limit_cut)
    else $error("cut released");
  cut_bypass_a: assert property ($rose(mod_limit_cut) |-> !$past(byp_q, 2))
    else $error("cut while bypassed");
  valid_pulse_a: assert property (sample_valid |=> !sample_valid)
    else $error("valid longer than a cycle");
endmodule // aio_cfg_props
bind aio_cfg aio_cfg_props i_aio_cfg_props (.*);

//--- bench/aio_src_model.sv
// Serial audio source acting as link master.
// Assumes the receiver samples data on rising bit clock edges.
`timescale 1ns/1ps
module aio_src_model (
  // Link pins toward the receiver
  output logic bclk,
  output logic wclk,
  output logic sdata
);
  // Bit clock stands low between frames; word clock starts high
  initial begin
    bclk = 1'b0;
    wclk = 1'b1;
    sdata = 1'b0;
  end
  // Three frames of h slots per half; slot 0 goes out first.
  // Three frames let a new format latch before the checked frame.
  task automatic send(input logic [31:0] sl, sr, input int h, input logic lpol);
    for (int f = 0; f < 6; f++)
      for (int i = 0; i < h; i++) begin
        wclk = f[0] ? !lpol : lpol;
        sdata = f[0] ? sr[i] : sl[i];
        #32 bclk = 1'b1;
        #32 bclk = 1'b0;
      end
    sdata = !sdata; // Released line shows the inverse of the last bit
  endtask
endmodule // aio_src_model

//--- bench/tb_aio_cfg.sv
// Self-checking bench for the configuration bank and serial receiver.
// Assumes a 200 MHz core clock; the source model makes the link clock.
`timescale 1ns/1ps
module tb_aio_cfg;
  // Core clock, reset and register port
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic        reg_wr = 1'b0, reg_rd = 1'b0;
  // Link, warning pin and decoded outputs
  logic        serial_bit_clock_in, word_clock_in, serial_data_in;
  logic        overcurrent_warning_n = 1'b1;
  logic [23:0] ch1_sample, ch2_sample;
  logic        sample_valid, bit_ratio_32, mod_limit_cut, highpass_en, deemphasis_en;
  logic [1:0]  output_stage_mode;
  logic [6:0]  comp_pulse_cyc;
  int          n_errors = 0, n_checks = 0, cyc = 0, nv = 0;
  always #2.5 mclk = !mclk;
  aio_cfg i_aio_cfg (.*);
  aio_src_model i_aio_src_model (.bclk(serial_bit_clock_in), .wclk(word_clock_in),
    .sdata(serial_data_in));
  // Cycle ceiling and valid pulse count
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (sample_valid === 1'b1) nv <= nv + 1;
    if (cyc == 40000) begin
      n_errors++;
      close_out;
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge mclk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(posedge mclk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, exp);
  endtask
  task automatic t_reset;
    rd(8'h01, 8'h80);
    rd(8'h02, 8'hc2);
    rd(8'h03, 8'h40);
    rd(8'h10, 8'h00); // Unmapped place reads zero
    chk("highpass_en", highpass_en, 1);
    $display("test reset done");
  endtask
  task automatic t_decode;
    logic [7:0] tv[6] = '{8'hfc, 8'hfd, 8'hfe, 8'hff, 8'h83, 8'h87};
    foreach (tv[k]) begin
      wr(8'h02, tv[k]);
      repeat (3) @(posedge mclk);
      #1 chk("output_stage_mode", output_stage_mode, tv[k][1:0]);
      chk("comp_pulse_cyc", comp_pulse_cyc, tv[k][1:0] == 2'h3 ? tv[k][6:2] * 2 : 0);
    end
    wr(8'h03, 8'h43);
    repeat (3) @(posedge mclk);
    #1 chk("highpass_en", highpass_en, 0);
    chk("deemphasis_en", deemphasis_en, 1);
    rd(8'h03, 8'h43);
    wr(8'h03, 8'h40);
    wr(8'h02, 8'hc2);
    $display("test decode done");
  endtask
  task automatic t_cut;
    @(posedge mclk) overcurrent_warning_n <= 1'b0;
    repeat (12) @(posedge mclk);
    #1 chk("cut while bypassed", mod_limit_cut, 0);
    wr(8'h02, 8'h42);
    repeat (8) @(posedge mclk);
    #1 chk("cut applied", mod_limit_cut, 1);
    @(posedge mclk) overcurrent_warning_n <= 1'b1;
    wr(8'h02, 8'hc2);
    repeat (8) @(posedge mclk);
    #1 chk("cut held", mod_limit_cut, 1);
    @(posedge mclk) nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk) #1 chk("cut after reset", mod_limit_cut, 0);
    $display("test cut done");
  endtask
  // Slot image of one half: framing 0 I2S, 1 left, 2 right justified
  function automatic logic [31:0] slots(input logic [23:0] d, input int h, w, fr, lsb);
    logic [31:0] s;
    int off;
    s = '1;
    off = (fr == 0) ? 1 : (fr == 1) ? 0 : h - w;
    for (int i = 0; i < w; i++) s[off + i] = lsb ? d[i] : d[w - 1 - i];
    return s;
  endfunction
  task automatic t_link;
    logic [7:0] cf[9] = '{8'h80, 8'h41, 8'ha2, 8'h85, 8'h88, 8'h9c, 8'h90, 8'h9c, 8'h9e};
    int hs[9] = '{32, 24, 32, 32, 24, 32, 32, 16, 16};
    int ws[9] = '{24, 24, 24, 20, 18, 16, 24, 15, 16};
    int fs[9] = '{0, 1, 2, 1, 0, 0, 0, 0, 1};
    int ls[9] = '{0, 0, 0, 0, 0, 1, 0, 0, 1};
    logic [23:0] l, r;
    foreach (cf[k]) begin
      l = 24'hb4d2e7 & ((24'h1 << ws[k]) - 1);
      r = 24'h6b1d59 & ((24'h1 << ws[k]) - 1);
      wr(8'h01, cf[k]);
      nv = 0;
      i_aio_src_model.send(slots(l, hs[k], ws[k], fs[k], ls[k]),
        slots(r, hs[k], ws[k], fs[k], ls[k]), hs[k], fs[k] != 0);
      repeat (20) @(posedge mclk);
      #1 chk("ch1_sample", ch1_sample, (cf[k][6] ? r : l) << (24 - ws[k]));
      chk("ch2_sample", ch2_sample, (cf[k][7] ? r : l) << (24 - ws[k]));
      chk("bit_ratio_32", bit_ratio_32, hs[k] == 16);
      chk("sample_valid seen", nv != 0, 1);
    end
    $display("test link done");
  endtask
  task automatic close_out;
    $display("Checks made %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    t_reset;
    t_decode;
    t_cut;
    t_link;
    close_out;
  end
endmodule // tb_aio_cfg
